//--- design/eesu_entry.sv
// exception entry state update: status, saved status, return address, fault info
// assumes pipeline requests and controller requests synchronous to clk_sys
//
// What this block does
// RULE_01: set switch flag when requested set differs
// RULE_02: data access flag follows data fault
// RULE_03: double miss flag on miss during handling
// RULE_04: permission flag follows permission violation
// RULE_05: bad address flag follows bad virtual address
// RULE_06: maskable external irq loads enable from auto nest
// RULE_07: internal irq or exception clears enable
// RULE_08: exception active flag set on entry
// RULE_09: entry clears user mode bit
// RULE_10: return address is next instruction
// RULE_11: cause holds highest priority exception code
// RULE_12: capture faulting byte address when reported
// RULE_13: external irq leaves cause untouched
// RULE_14: cause and address always with translation unit
// RULE_15: same nonzero set blocked when preemption disabled
// RULE_16: same set taken at higher level
// RULE_17: auto nest off disables irqs on entry
// RULE_18: nonmaskable entry always disables irqs
// RULE_19: nonmaskable preempts maskable, never preempted by another nonmaskable
// RULE_20: maskable entry during nonmaskable leaves that mode
// RULE_21: pending register reads zero
// RULE_22: level must exceed threshold
// RULE_23: enable clear ignores all maskable irqs
// RULE_24: exception active preserves saved registers
// RULE_25: all updates land with fetch redirect
//
// Strobed register access and the placing of the registers were chosen for this implementation.
module eesu_entry import eesu_pkg::*; (
	input  wire logic                   clk_sys,
	input  wire logic                   rst_b,
	input  wire logic [EESU_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [31:0]            reg_rdata,
	input  wire eesu_exc_req_t          exc_in,
	input  wire logic                   int_irq_req,
	input  wire eesu_eic_req_t          eic_in,
	input  wire logic [31:0]            exec_pc,
	output logic                        eic_ack,
	output logic                        int_ack,
	output logic                        redirect,
	output logic      [31:0]            handler_addr,
	output eesu_status_t                status_out
);

	logic [1:0]   rst_sync_q;   // reset release chain
	logic         rst_int_b;    // synchronised reset
	eesu_state_t  st_q;         // block state but reset chain and saved status store
	eesu_state_t  st_d;         // next state
	eesu_status_t cur;          // live status shorthand
	logic         eh;           // exception in progress
	logic         extra_on;     // cause and address captured
	logic         same_set_blk; // same set preemption blocked
	logic         take_nmi;     // nonmaskable irq taken
	logic         take_mask;    // maskable external irq taken
	logic         take_ext;     // any external irq taken
	logic         take_int;     // internal irq taken
	logic         take_exc;     // noninterrupt exception taken
	logic         take_any;     // any entry this cycle
	logic [31:0]  ret_addr;     // address after executing one
	logic         sstat_we;     // saved status store write
	logic [2:0]   sstat_waddr;  // saved status store set
	logic [31:0]  sstat_wdata;  // saved status store word
	logic [31:0]  sstat_rdata;  // saved status of running set
	eesu_status_t sstat_entry;  // status saved into new set

	// release reset through two flops, assert at once
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_int_b = rst_sync_q[1];

	assign cur      = st_q.status;
	assign eh       = cur.exception_active_flag;
	assign extra_on = EESU_EXTRA_INFO | EESU_MMU_PRESENT; // RULE_14
	assign ret_addr = exec_pc + EESU_INSN_STEP; // RULE_10

	// same set blocked only while preemption in set is off
	assign same_set_blk = (eic_in.requested_shadow_set == cur.current_shadow_set)
		&& (cur.current_shadow_set != 3'h0)
		&& !cur.same_set_preempt_enable; // RULE_15

	// nonmaskable beats maskable, never nests into itself
	assign take_nmi = eic_in.valid && eic_in.nmi && !cur.nmi_mode
		&& !exc_in.valid; // RULE_19

	// maskable: enable, strict level test, set gating
	assign take_mask = eic_in.valid && !eic_in.nmi && cur.global_irq_enable // RULE_23
		&& (eic_in.requested_level > cur.level_threshold) // RULE_22 RULE_16
		&& !same_set_blk && !exc_in.valid;

	assign take_ext = take_nmi || take_mask;
	assign take_int = int_irq_req && cur.global_irq_enable && !exc_in.valid
		&& !take_ext; // RULE_23
	assign take_exc = exc_in.valid;
	assign take_any = take_ext || take_int || take_exc;
	assign eic_ack  = take_ext;
	assign int_ack  = take_int;

	// saved status copied into a nonzero requested set
	always_comb begin
		sstat_entry = cur;
		sstat_entry.shadow_switch_flag =
			(eic_in.requested_shadow_set != cur.current_shadow_set); // RULE_01
	end

	// store write: entry into a shadow set wins over software
	always_comb begin
		sstat_we    = 1'b0;
		sstat_waddr = cur.current_shadow_set;
		sstat_wdata = reg_wdata;
		if (take_ext && !eh && (eic_in.requested_shadow_set != 3'h0)) begin
			sstat_we    = 1'b1; // RULE_24
			sstat_waddr = eic_in.requested_shadow_set;
			sstat_wdata = sstat_entry;
		end else if (reg_wr && (reg_addr == EESU_OFF_SSTATUS)) begin
			sstat_we = 1'b1;
		end
	end

	eesu_sstat_mem u_sstat (
		.clk_sys (clk_sys),
		.wr_en   (sstat_we),
		.wr_addr (sstat_waddr),
		.wr_data (sstat_wdata),
		.rd_addr (cur.current_shadow_set),
		.rd_data (sstat_rdata)
	);

	// next state: reads, writes, then exception entry on top
	always_comb begin
		eesu_status_t ns;
		ns = cur;
		st_d = st_q;
		st_d.redirect  = 1'b0;
		st_d.sstat_sel = 1'b0;
		// register reads, data next cycle
		if (reg_rd) begin
			case (reg_addr)
				EESU_OFF_STATUS:   st_d.rdata = st_q.status;
				EESU_OFF_ESTATUS:  st_d.rdata = st_q.estatus;
				EESU_OFF_SSTATUS: begin
					st_d.rdata     = 32'h0000_0000;
					st_d.sstat_sel = 1'b1;
				end
				EESU_OFF_RETADDR:  st_d.rdata = st_q.exception_return_address;
				EESU_OFF_CONFIG:   st_d.rdata = {31'h0, st_q.auto_nest_enable};
				EESU_OFF_CAUSE: begin
					st_d.rdata = 32'h0000_0000;
					st_d.rdata[EESU_CAUSE_LSB +: EESU_CAUSE_W] = st_q.cause;
				end
				EESU_OFF_FAULTING_ADDRESS_FIELD:    st_d.rdata = st_q.faulting_address_field;
				EESU_OFF_TLBMISC:  st_d.rdata = st_q.tlbmisc;
				EESU_OFF_IPENDING: st_d.rdata = 32'h0000_0000; // RULE_21
				default:           st_d.rdata = 32'h0000_0000; // unmapped
			endcase
		end
		// register writes, read-only ones ignored
		if (reg_wr) begin
			case (reg_addr)
				EESU_OFF_STATUS: begin
					st_d.status     = reg_wdata;
					st_d.status.pad = 13'h0000;
				end
				EESU_OFF_ESTATUS: begin
					st_d.estatus     = reg_wdata;
					st_d.estatus.pad = 13'h0000;
				end
				EESU_OFF_RETADDR: st_d.exception_return_address = reg_wdata;
				EESU_OFF_CONFIG:  st_d.auto_nest_enable = reg_wdata[0];
				default: begin
				end
			endcase
		end
		// entry takes effect with the redirect, over software writes
		if (take_any) begin
			st_d.redirect = 1'b1; // RULE_25
			ns.user_mode  = 1'b0; // RULE_09
			ns.exception_active_flag = EESU_MMU_PRESENT; // RULE_08
			ns.prev_shadow_set = cur.current_shadow_set;
			if (take_ext) begin
				// nonmaskable always off, maskable follows auto nest
				ns.global_irq_enable = take_nmi ? 1'b0 : st_q.auto_nest_enable; // RULE_06 RULE_17 RULE_18
				ns.nmi_mode = take_nmi; // RULE_20
				ns.irq_handler_flag   = 1'b1;
				ns.level_threshold    = eic_in.requested_level;
				ns.current_shadow_set = eic_in.requested_shadow_set;
				// cause left alone for controller irqs
				if (!eh) begin // RULE_13 RULE_24
					if (eic_in.requested_shadow_set == 3'h0) begin
						st_d.estatus = cur;
					end
					st_d.exception_return_address = ret_addr; // RULE_10
				end
				st_d.handler = eic_in.handler;
			end else begin
				ns.global_irq_enable  = 1'b0; // RULE_07
				ns.current_shadow_set = 3'h0;
				if (!eh) begin // RULE_24
					st_d.estatus = cur;
					st_d.exception_return_address = ret_addr; // RULE_10
					if (extra_on) begin
						// pipeline code, or fixed irq code
						st_d.cause = take_exc ? exc_in.cause : EESU_CAUSE_IRQ; // RULE_11
						if (take_exc && exc_in.addr_valid) begin
							st_d.faulting_address_field = exc_in.addr; // RULE_12
						end
					end
				end
				// translation flags, double miss from handling state
				if (take_exc && exc_in.tlb) begin
					st_d.tlbmisc = 32'h0000_0000;
					st_d.tlbmisc.data_access_flag = exc_in.data_access; // RULE_02
					st_d.tlbmisc.double_miss_flag = exc_in.tlb_miss && eh; // RULE_03
					st_d.tlbmisc.access_right_violation_flag = exc_in.access_right_violation_flag_viol; // RULE_04
					st_d.tlbmisc.bad_address_flag = exc_in.bad_vaddr; // RULE_05
				end
				st_d.handler = (take_exc && exc_in.tlb_miss && !eh)
					? EESU_TLB_VECTOR : EESU_GEN_VECTOR;
			end
			st_d.status = ns;
		end
	end

	// state register on synchronised reset
	always_ff @(posedge clk_sys or negedge rst_int_b) begin
		if (!rst_int_b) begin
			st_q <= '0;
			st_q.status <= EESU_STATUS_RST;
			st_q.auto_nest_enable <= EESU_CFG_RST;
			st_q.handler <= EESU_GEN_VECTOR;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs from flops
	assign redirect     = st_q.redirect;
	assign handler_addr = st_q.handler;
	assign status_out   = st_q.status;
	assign reg_rdata    = st_q.sstat_sel ? sstat_rdata : st_q.rdata;

	// checks of the entry behaviour
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_int_b);

	// entry sequences
	sequence s_ext_fresh;
		take_ext && !eh;
	endsequence
	sequence s_redirected;
		redirect && status_out.exception_active_flag && !status_out.user_mode;
	endsequence

	switch_flag_a: assert property ( // RULE_01
		(s_ext_fresh and (eic_in.requested_shadow_set != 3'h0))
		|-> sstat_we && (sstat_wdata[18] == (eic_in.requested_shadow_set
			!= cur.current_shadow_set)))
		else $error("switch flag not saved with shadow status");

	tlb_flags_a: assert property ( // RULE_02
		(take_exc && exc_in.tlb)
		|=> (st_q.tlbmisc[3:0] == {$past(exc_in.bad_vaddr), $past(exc_in.access_right_violation_flag_viol),
			$past(exc_in.tlb_miss) && $past(eh), $past(exc_in.data_access)}))
		else $error("translation fault flags wrong after entry");

	ext_enable_a: assert property ( // RULE_06
		take_mask |=> status_out.global_irq_enable == $past(st_q.auto_nest_enable))
		else $error("irq enable not loaded from auto nest");

	irq_off_a: assert property ( // RULE_07
		(take_int || take_exc || take_nmi) |=> !status_out.global_irq_enable)
		else $error("irq enable not cleared on entry");

	entry_redirect_a: assert property ( // RULE_25
		take_any |=> s_redirected ##1 !redirect)
		else $error("redirect and status not updated together");

	return_addr_a: assert property ( // RULE_10
		(take_any && !eh)
		|=> st_q.exception_return_address == $past(exec_pc) + EESU_INSN_STEP)
		else $error("return address not next instruction");

	cause_hold_a: assert property ( // RULE_13
		(take_ext && !reg_wr) |=> $stable(st_q.cause))
		else $error("external irq changed cause");

	same_set_a: assert property ( // RULE_15
		same_set_blk |-> !take_mask)
		else $error("same set irq taken with preemption off");

	level_gate_a: assert property ( // RULE_22
		take_mask |-> (eic_in.requested_level > cur.level_threshold)
			&& cur.global_irq_enable)
		else $error("maskable irq taken below threshold or disabled");

	nmi_nest_a: assert property ( // RULE_19
		(cur.nmi_mode && !cur.global_irq_enable) |-> !take_ext && !take_int)
		else $error("nonmaskable handler preempted");

	nmi_exit_a: assert property ( // RULE_20
		(cur.nmi_mode && take_mask) |=> !status_out.nmi_mode ##1 !$rose(status_out.nmi_mode)
			|| $past(take_nmi))
		else $error("nonmaskable mode kept after maskable entry");

	preserve_a: assert property ( // RULE_24
		(take_exc && eh && !reg_wr) |=> $stable(st_q.estatus)
			&& $stable(st_q.exception_return_address))
		else $error("saved state overwritten while exception active");

	pending_zero_a: assert property ( // RULE_21
		(reg_rd && reg_addr == EESU_OFF_IPENDING) |=> reg_rdata == 32'h0000_0000)
		else $error("pending register not zero");

	// every entry lands in supervisor mode
	user_mode_a: assert property ( // RULE_09
		take_any |=> !status_out.user_mode)
		else $error("user mode kept after entry");

	// in-progress flag follows the translation unit option
	exc_active_a: assert property ( // RULE_08
		take_any |=> status_out.exception_active_flag == EESU_MMU_PRESENT)
		else $error("exception active flag not set on entry");

	// pipeline code captured on a fresh exception
	cause_code_a: assert property ( // RULE_11
		(take_exc && !eh) |=> st_q.cause == $past(exc_in.cause))
		else $error("cause not captured on entry");

	// reported address captured on a fresh exception
	fault_addr_a: assert property ( // RULE_12
		(take_exc && !eh && exc_in.addr_valid)
		|=> st_q.faulting_address_field == $past(exc_in.addr))
		else $error("faulting address not captured");

	// no auto nesting: maskable entry turns irqs off
	nest_off_a: assert property ( // RULE_17
		(take_mask && !st_q.auto_nest_enable) |=> !status_out.global_irq_enable)
		else $error("irq enable left on with auto nest off");

endmodule

//--- pkg/eesu_pkg.sv
// constants, field layouts and carrier types for exception entry state update
// assumes one 10 MHz system clock and a byte-addressed 32-bit register port with 8-bit addresses
package eesu_pkg;

	// register port geometry
	localparam int unsigned EESU_ADDR_W = 8;
	localparam int unsigned EESU_DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] EESU_OFF_STATUS   = 8'h00; // live status
	localparam logic [7:0] EESU_OFF_ESTATUS  = 8'h04; // saved status, normal set
	localparam logic [7:0] EESU_OFF_SSTATUS  = 8'h08; // saved status of running set
	localparam logic [7:0] EESU_OFF_RETADDR  = 8'h0c; // exception return address
	localparam logic [7:0] EESU_OFF_CONFIG   = 8'h10; // bit 0 auto nest enable
	localparam logic [7:0] EESU_OFF_CAUSE    = 8'h14; // cause code, bits 6:2
	localparam logic [7:0] EESU_OFF_FAULTING_ADDRESS_FIELD    = 8'h18; // faulting address
	localparam logic [7:0] EESU_OFF_TLBMISC  = 8'h1c; // translation fault flags
	localparam logic [7:0] EESU_OFF_IPENDING = 8'h20; // pending irqs, always zero

	// build options
	localparam logic EESU_MMU_PRESENT = 1'b1; // translation unit fitted
	localparam logic EESU_EXTRA_INFO  = 1'b0; // extra exception info option
	localparam int unsigned EESU_NSETS  = 8;  // shadow register sets
	localparam int unsigned EESU_SET_W  = 3;
	localparam int unsigned EESU_LVL_W  = 6;

	// cause field position and codes
	localparam int unsigned EESU_CAUSE_LSB = 2;
	localparam int unsigned EESU_CAUSE_W   = 5;
	localparam logic [4:0]  EESU_CAUSE_IRQ = 5'h02; // internal interrupt

	// handler vectors and return step
	localparam logic [31:0] EESU_GEN_VECTOR = 32'h0000_0020;
	localparam logic [31:0] EESU_TLB_VECTOR = 32'h0000_0100;
	localparam logic [31:0] EESU_INSN_STEP  = 32'h0000_0004;

	// reset values
	localparam logic [31:0] EESU_STATUS_RST = 32'h0000_0000; // supervisor, irqs off
	localparam logic        EESU_CFG_RST    = 1'b0;          // no auto nesting

	// status word layout
	typedef struct packed {
		logic [12:0] pad;                       // reads as zero
		logic        shadow_switch_flag;        // set switched on entry
		logic        same_set_preempt_enable;   // allow same-set preemption
		logic [2:0]  prev_shadow_set;           // set before entry
		logic [2:0]  current_shadow_set;        // running set
		logic [5:0]  level_threshold;           // irq level threshold
		logic        nmi_mode;                  // nonmaskable handler running
		logic        irq_handler_flag;          // external irq handler running
		logic        exception_active_flag;     // exception in progress
		logic        user_mode;                 // 1 user, 0 supervisor
		logic        global_irq_enable;         // maskable irq enable
	} eesu_status_t;

	// translation fault flags
	typedef struct packed {
		logic [27:0] pad;
		logic        bad_address_flag;
		logic        access_right_violation_flag;
		logic        double_miss_flag;
		logic        data_access_flag;
	} eesu_tlbmisc_t;

	// request from external interrupt controller
	typedef struct packed {
		logic        valid;        // request present
		logic        nmi;          // nonmaskable
		logic [5:0]  requested_level;
		logic [2:0]  requested_shadow_set;
		logic [31:0] handler;      // handler address
	} eesu_eic_req_t;

	// noninterrupt exception from pipeline
	typedef struct packed {
		logic        valid;        // exception raised
		logic [4:0]  cause;        // highest priority cause
		logic        addr_valid;   // cause reports an address
		logic [31:0] addr;         // faulting byte address
		logic        tlb;          // translation related
		logic        tlb_miss;     // translation miss
		logic        data_access;  // data side access
		logic        access_right_violation_flag_viol;    // permission violation
		logic        bad_vaddr;    // bad virtual address
	} eesu_exc_req_t;

	// state of the entry block but reset chain and saved status store
	typedef struct packed {
		eesu_status_t  status;
		eesu_status_t  estatus;
		logic [31:0]   exception_return_address;
		logic          auto_nest_enable;
		logic [4:0]    cause;
		logic [31:0]   faulting_address_field;
		eesu_tlbmisc_t tlbmisc;
		logic [31:0]   rdata;
		logic          sstat_sel;
		logic          redirect;
		logic [31:0]   handler;
	} eesu_state_t;

endpackage

//--- design/eesu_sstat_mem.sv
// saved-status store, one word per shadow register set
// assumes synchronous single clock; read data registered, no reset on storage
module eesu_sstat_mem import eesu_pkg::*; (
	input  wire logic                  clk_sys,
	input  wire logic                  wr_en,
	input  wire logic [EESU_SET_W-1:0] wr_addr,
	input  wire logic [31:0]           wr_data,
	input  wire logic [EESU_SET_W-1:0] rd_addr,
	output logic      [31:0]           rd_data
);

	logic [31:0] mem_q [EESU_NSETS]; // one saved status per set

	// write port and registered read port
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
		rd_data <= mem_q[rd_addr];
	end

endmodule

//--- sim/eesu_eic_model.sv
// external interrupt controller model: holds one request until the core takes it
// assumes bench loads arrive as one-cycle ld pulses synchronous to clk_sys
module eesu_eic_model import eesu_pkg::*; (
	input  wire logic          clk_sys,
	input  wire logic          rst_b,
	input  wire logic          ld,
	input  wire eesu_eic_req_t ld_req,
	input  wire logic          eic_ack,
	output eesu_eic_req_t      eic_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// released request: fields flip so stale values never look steady
	function automatic eesu_eic_req_t drop(input eesu_eic_req_t r);
		eesu_eic_req_t n;
		n       = ~r;
		n.valid = 1'b0;
		return n;
	endfunction

	// request register: load, withdraw, or release once acked
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			eic_in <= '0;
		end else if (ld) begin
			eic_in <= ld_req.valid ? ld_req : drop(eic_in);
		end else if (eic_in.valid && eic_ack) begin
			eic_in <= drop(eic_in);
		end
	end
endmodule

//--- sim/tb.sv
// self-checking bench for the exception entry block
// assumes eesu_entry as top, controller model on the eic side, 10 MHz clock
module tb import eesu_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;

	logic                   clk_sys;      // system clock
	logic                   rst_b;        // reset, active low
	logic [EESU_ADDR_W-1:0] reg_addr;     // register address
	logic [31:0]            reg_wdata;    // write data
	logic                   reg_wr;       // write strobe
	logic                   reg_rd;       // read strobe
	logic [31:0]            reg_rdata;    // read data
	eesu_exc_req_t          exc_in;       // pipeline exception
	logic                   int_irq_req;  // internal irq
	eesu_eic_req_t          eic_in;       // controller request
	logic [31:0]            exec_pc;      // executing pc
	logic                   eic_ack;      // external take
	logic                   int_ack;      // internal take
	logic                   redirect;     // fetch redirect
	logic [31:0]            handler_addr; // handler vector
	eesu_status_t           status_out;   // live status
	logic                   ld;           // model load pulse
	eesu_eic_req_t          ld_req;       // model load value
	eesu_exc_req_t          ex;           // exception under test
	int                     error_cnt;    // mismatches
	int                     cmp_count;    // comparisons

	// clock, 100 ns period
	always #50 clk_sys = ~clk_sys;

	eesu_entry i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.exc_in(exc_in), .int_irq_req(int_irq_req), .eic_in(eic_in), .exec_pc(exec_pc),
		.eic_ack(eic_ack), .int_ack(int_ack), .redirect(redirect),
		.handler_addr(handler_addr), .status_out(status_out));

	eesu_eic_model i_eic (.clk_sys(clk_sys), .rst_b(rst_b), .ld(ld), .ld_req(ld_req),
		.eic_ack(eic_ack), .eic_in(eic_in));

	// verdict and end of run
	task automatic summarize;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// compare seen against expected
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// one-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask

	// one-cycle register read, data checked in the following cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1 check(nm, reg_rdata, exp);
	endtask

	// status word with enable, threshold, set and same-set preemption
	function automatic logic [31:0] mk(input logic en, input logic [5:0] lvl,
		input logic [2:0] set, input logic pre);
		eesu_status_t s;
		s                         = '0;
		s.global_irq_enable       = en;
		s.level_threshold         = lvl;
		s.current_shadow_set      = set;
		s.same_set_preempt_enable = pre;
		return s;
	endfunction

	// hand a request to the controller model
	task automatic load(input logic v, input logic n, input logic [5:0] l,
		input logic [2:0] s, input logic [31:0] h);
		@(posedge clk_sys);
		ld     <= 1'b1;
		ld_req <= '{valid: v, nmi: n, requested_level: l, requested_shadow_set: s, handler: h};
		@(posedge clk_sys);
		ld     <= 1'b0;
	endtask

	// no take of any kind for four cycles
	task automatic no_ack;
		repeat (4) begin
			@(negedge clk_sys);
			check("eic_ack", 32'(eic_ack), 32'h0);
			check("int_ack", 32'(int_ack), 32'h0);
		end
	endtask

	// wait for a take, then expect redirect with the handler next cycle
	task automatic take(input logic internal, input logic [31:0] h);
		logic got;
		got = 1'b0;
		for (int i = 0; i < 20 && !got; i++) begin
			@(negedge clk_sys);
			got = internal ? (int_ack === 1'b1) : (eic_ack === 1'b1);
		end
		if (!got) begin
			check("take_timeout", 32'(got), 32'h1);
			summarize();
		end
		@(posedge clk_sys);
		int_irq_req <= 1'b0;
		#1 check("redirect", 32'(redirect), 32'h1);
		check("handler", handler_addr, h);
		@(posedge clk_sys);
		#1 check("redirect_end", 32'(redirect), 32'h0);
	endtask

	// pipeline exception pulse; released fields are flipped
	task automatic raise(input eesu_exc_req_t e);
		eesu_exc_req_t r;
		r       = ~e;
		r.valid = 1'b0;
		@(posedge clk_sys);
		exc_in <= e;
		@(posedge clk_sys);
		exc_in <= r;
		#1 check("redirect", 32'(redirect), 32'h1);
		check("handler", handler_addr, EESU_GEN_VECTOR);
	endtask

	// live status fields after an entry
	task automatic chk_st(input logic en, input logic nmi, input logic [2:0] set,
		input logic [5:0] lvl);
		check("enable", 32'(status_out.global_irq_enable), 32'(en));
		check("user", 32'(status_out.user_mode), 32'h0);
		check("nmi", 32'(status_out.nmi_mode), 32'(nmi));
		check("set", 32'(status_out.current_shadow_set), 32'(set));
		check("level", 32'(status_out.level_threshold), 32'(lvl));
	endtask

	// main sequence
	initial begin
		clk_sys = 1'b0;
		rst_b = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		exc_in = '0;
		int_irq_req = 1'b0;
		exec_pc = 32'h0000_1000;
		ld = 1'b0;
		ld_req = '0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		// reset values and read-only places
		#1 check("status_rst", status_out, EESU_STATUS_RST);
		rd(EESU_OFF_IPENDING, 32'h0, "ipending");
		wr(EESU_OFF_IPENDING, 32'hffff_ffff);
		rd(EESU_OFF_IPENDING, 32'h0, "ipending_wr");
		rd(8'h44, 32'h0, "unmapped");
		rd(EESU_OFF_CONFIG, 32'h0, "config_rst");
		// internal irq blocked while disabled, then taken
		@(posedge clk_sys);
		int_irq_req <= 1'b1;
		no_ack();
		wr(EESU_OFF_STATUS, 32'h0000_0003);
		take(1'b1, EESU_GEN_VECTOR);
		chk_st(1'b0, 1'b0, 3'h0, 6'h0);
		check("exc_active", 32'(status_out.exception_active_flag), 32'h1);
		rd(EESU_OFF_RETADDR, 32'h0000_1004, "retaddr");
		rd(EESU_OFF_ESTATUS, 32'h0000_0003, "estatus");
		rd(EESU_OFF_CAUSE, 32'(EESU_CAUSE_IRQ) << EESU_CAUSE_LSB, "cause_irq");
		// translation fault, then a miss while still active
		wr(EESU_OFF_STATUS, 32'h0);
		exec_pc <= 32'h0000_2000;
		ex = '{valid: 1'b1, cause: 5'h0c, addr_valid: 1'b1, addr: 32'h0000_3a5c, tlb: 1'b1,
			tlb_miss: 1'b0, data_access: 1'b1, access_right_violation_flag_viol: 1'b1, bad_vaddr: 1'b0};
		raise(ex);
		rd(EESU_OFF_TLBMISC, 32'h0000_0005, "tlbmisc");
		rd(EESU_OFF_CAUSE, 32'h0000_0030, "cause");
		rd(EESU_OFF_FAULTING_ADDRESS_FIELD, 32'h0000_3a5c, "faulting_address_field");
		rd(EESU_OFF_RETADDR, 32'h0000_2004, "retaddr");
		@(posedge clk_sys);
		exec_pc <= 32'h0000_2100;
		ex = '{valid: 1'b1, cause: 5'h0f, addr_valid: 1'b1, addr: 32'h0000_77c0, tlb: 1'b1,
			tlb_miss: 1'b1, data_access: 1'b0, access_right_violation_flag_viol: 1'b0, bad_vaddr: 1'b1};
		raise(ex);
		rd(EESU_OFF_TLBMISC, 32'h0000_000a, "tlbmisc_dbl");
		rd(EESU_OFF_CAUSE, 32'h0000_0030, "cause_kept");
		rd(EESU_OFF_FAULTING_ADDRESS_FIELD, 32'h0000_3a5c, "faulting_address_field_kept");
		rd(EESU_OFF_RETADDR, 32'h0000_2004, "retaddr_kept");
		// level at threshold refused, one above taken, auto nest off
		wr(EESU_OFF_STATUS, mk(1'b1, 6'h2, 3'h0, 1'b0));
		exec_pc <= 32'h0000_3000;
		load(1'b1, 1'b0, 6'h2, 3'h3, 32'h0000_0400);
		no_ack();
		wr(EESU_OFF_STATUS, mk(1'b1, 6'h1, 3'h0, 1'b0));
		take(1'b0, 32'h0000_0400);
		chk_st(1'b0, 1'b0, 3'h3, 6'h2);
		rd(EESU_OFF_SSTATUS, 32'h0004_0021, "sstatus_sw");
		rd(EESU_OFF_CAUSE, 32'h0000_0030, "cause_ext");
		rd(EESU_OFF_RETADDR, 32'h0000_3004, "retaddr_ext");
		// same-set request blocked, then allowed by preemption, auto nest on
		wr(EESU_OFF_CONFIG, 32'h1);
		rd(EESU_OFF_CONFIG, 32'h1, "config");
		wr(EESU_OFF_STATUS, mk(1'b1, 6'h2, 3'h3, 1'b0));
		load(1'b1, 1'b0, 6'h5, 3'h3, 32'h0000_0500);
		no_ack();
		wr(EESU_OFF_STATUS, mk(1'b1, 6'h2, 3'h3, 1'b1));
		take(1'b0, 32'h0000_0500);
		chk_st(1'b1, 1'b0, 3'h3, 6'h5);
		rd(EESU_OFF_SSTATUS, 32'h0002_1841, "sstatus_same");
		// nonmaskable preempts, refuses a second, maskable leaves the mode
		load(1'b1, 1'b1, 6'h6, 3'h4, 32'h0000_0600);
		take(1'b0, 32'h0000_0600);
		chk_st(1'b0, 1'b1, 3'h4, 6'h6);
		load(1'b1, 1'b1, 6'h3f, 3'h5, 32'h0000_0700);
		no_ack();
		load(1'b0, 1'b0, 6'h0, 3'h0, 32'h0);
		wr(EESU_OFF_STATUS, 32'(status_out) | 32'h1);
		load(1'b1, 1'b0, 6'h7, 3'h1, 32'h0000_0800);
		take(1'b0, 32'h0000_0800);
		chk_st(1'b1, 1'b0, 3'h1, 6'h7);
		summarize();
	end
endmodule
